/* File: rtl/cam_consts.vh */
`ifndef CAM_CONSTS_VH
`define CAM_CONSTS_VH
`define CAM_MODE_ADDR     8'hD9
`define CAM_CTRL_ADDR     8'hD8
`define CAM_MODE_RESET    8'h40
`define CAM_BIT_IDLE      7
`define CAM_BIT_WDEN      6
`define CAM_BIT_LOCK      5
`define CAM_BIT_RSVD      4
`define CAM_TB_HI         3
`define CAM_TB_LO         1
`define CAM_BIT_IRQEN     0
`define CAM_BIT_OVF       7
`define CAM_BIT_RUN       6
`define CAM_TB_DIV12      3'h0
`define CAM_TB_DIV4       3'h1
`define CAM_TB_T0OVF      3'h2
`define CAM_TB_EXTIN      3'h3
`define CAM_TB_SYSCLK     3'h4
`define CAM_TB_EXTCLK     3'h5
`define CAM_TB_RTC        3'h6
`define CAM_DIV12_LAST    4'hB
`define CAM_DIV4_LAST     4'h3
`define CAM_CNT_MAX       16'hFFFF
`define CAM_CNT_ZERO      16'h0000
`endif

/* File: rtl/cam_mode_ctrl.v */
`timescale 1ns/1ps
`include "cam_consts.vh"
module cam_mode_ctrl (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        nrst_i,
  // special function register port
  input  wire [7:0]  sfr_addr_i,
  input  wire [7:0]  sfr_wdata_i,
  input  wire        sfr_wr_i,
  output reg  [7:0]  sfr_rdata_o,
  // system state and timebase sources
  input  wire        cpu_idle_i,
  input  wire        t0_ovf_i,
  input  wire        ext_count_input_i,
  input  wire        ext_clk_div8_i,
  input  wire        rtc_clk_div8_i,
  // counter array outputs
  output reg  [15:0] counter_o,
  output wire        count_tick_o,
  output wire        watchdog_function_o,
  output wire        counter_array_irq_o
);
  // =====================================
  // registers
  localparam [7:0] MODE_RST = `CAM_MODE_RESET;

  reg        idle_suspend;
  reg        watchdog_enable;
  reg        watchdog_lock;
  reg  [2:0] timebase_select;
  reg        overflow_irq_enable;
  reg        counter_overflow_flag;
  reg        counter_run;
  reg  [3:0] prediv;

  // =====================================
  // next values and internal strobes
  reg        next_idle_suspend;
  reg        next_watchdog_enable;
  reg        next_watchdog_lock;
  reg  [2:0] next_timebase_select;
  reg        next_overflow_irq_enable;
  reg        next_counter_overflow_flag;
  reg  [3:0] next_prediv;
  reg        pre_tick;
  reg        tick;
  wire       ext_fall;
  wire       xclk_fall;
  wire       rtc_fall;
  wire       wr_mode;
  wire       wr_ctrl;
  wire       active;
  wire       wrap;

  // =====================================
  // helpers
  // one address compare shared by both write strobes and the read mux
  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // true for the selections that step through the system clock prescaler
  function prescaled;
    input [2:0] sel;
    begin
      prescaled = (sel == `CAM_TB_DIV12) || (sel == `CAM_TB_DIV4);
    end
  endfunction

  // last prescaler state of a divided selection
  function [3:0] pre_last;
    input [2:0] sel;
    begin
      if (sel == `CAM_TB_DIV12)
        pre_last = `CAM_DIV12_LAST;
      else
        pre_last = `CAM_DIV4_LAST;
    end
  endfunction

  assign wr_mode = sfr_wr_i && addr_hit(sfr_addr_i, `CAM_MODE_ADDR);
  assign wr_ctrl = sfr_wr_i && addr_hit(sfr_addr_i, `CAM_CTRL_ADDR);

  // =====================================
  // pin synchronisers; divided clocks count on falling edges so one tick per period
  cam_sync u_ext (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .async_i   (ext_count_input_i),
    .level_o   (),
    .fall_o    (ext_fall)
  );
  cam_sync u_xclk (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .async_i   (ext_clk_div8_i),
    .level_o   (),
    .fall_o    (xclk_fall)
  );
  cam_sync u_rtc (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .async_i   (rtc_clk_div8_i),
    .level_o   (),
    .fall_o    (rtc_fall)
  );

  // =====================================
  // mode register write; while the watchdog runs only lock, and enable while unlocked, respond
  always @* begin
    next_idle_suspend        = idle_suspend;
    next_watchdog_enable     = watchdog_enable;
    next_watchdog_lock       = watchdog_lock;
    next_timebase_select     = timebase_select;
    next_overflow_irq_enable = overflow_irq_enable;
    if (wr_mode) begin
      // the lock is set-only so a runaway program cannot undo it
      next_watchdog_lock = watchdog_lock | sfr_wdata_i[`CAM_BIT_LOCK];
      if (!watchdog_enable || !watchdog_lock)
        next_watchdog_enable = sfr_wdata_i[`CAM_BIT_WDEN];
      if (!watchdog_enable) begin
        next_idle_suspend        = sfr_wdata_i[`CAM_BIT_IDLE];
        next_timebase_select     = sfr_wdata_i[`CAM_TB_HI:`CAM_TB_LO];
        next_overflow_irq_enable = sfr_wdata_i[`CAM_BIT_IRQEN];
      end
    end
  end

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_suspend        <= MODE_RST[`CAM_BIT_IDLE];
      watchdog_enable     <= MODE_RST[`CAM_BIT_WDEN];
      watchdog_lock       <= MODE_RST[`CAM_BIT_LOCK];
      timebase_select     <= MODE_RST[`CAM_TB_HI:`CAM_TB_LO];
      overflow_irq_enable <= MODE_RST[`CAM_BIT_IRQEN];
    end else begin
      idle_suspend        <= next_idle_suspend;
      watchdog_enable     <= next_watchdog_enable;
      watchdog_lock       <= next_watchdog_lock;
      timebase_select     <= next_timebase_select;
      overflow_irq_enable <= next_overflow_irq_enable;
    end
  end

  // =====================================
  // prescaler for the divided system clock selections
  always @* begin
    next_prediv = prediv + 4'h1;
    pre_tick    = 1'b0;
    if (prescaled(timebase_select) && prediv >= pre_last(timebase_select)) begin
      next_prediv = 4'h0;
      pre_tick    = 1'b1;
    end
  end

  always @* begin
    case (timebase_select)
      `CAM_TB_DIV12,
      `CAM_TB_DIV4:   tick = pre_tick;
      `CAM_TB_T0OVF:  tick = t0_ovf_i;
      `CAM_TB_EXTIN:  tick = ext_fall;
      `CAM_TB_SYSCLK: tick = 1'b1;
      `CAM_TB_EXTCLK: tick = xclk_fall;
      `CAM_TB_RTC:    tick = rtc_fall;
      default:        tick = 1'b0;
    endcase
  end

  // idle suspend freezes prescaler and counter together
  assign active       = counter_run && !(idle_suspend && cpu_idle_i);
  assign count_tick_o = active && tick;
  assign wrap         = count_tick_o && (counter_o == `CAM_CNT_MAX);

  // =====================================
  // counter, run control and overflow flag
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      prediv <= 4'h0;
    else if (active)
      prediv <= next_prediv;
  end

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      counter_o <= `CAM_CNT_ZERO;
    else if (count_tick_o)
      counter_o <= counter_o + 16'h0001;
  end

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      counter_run <= 1'b0;
    else if (wr_ctrl)
      counter_run <= sfr_wdata_i[`CAM_BIT_RUN];
  end

  // hardware set wins over a same-cycle software clear, so no overflow is lost
  always @* begin
    next_counter_overflow_flag = counter_overflow_flag;
    if (wrap)
      next_counter_overflow_flag = 1'b1;
    else if (wr_ctrl && !sfr_wdata_i[`CAM_BIT_OVF])
      next_counter_overflow_flag = 1'b0;
  end

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      counter_overflow_flag <= 1'b0;
    else
      counter_overflow_flag <= next_counter_overflow_flag;
  end

  assign counter_array_irq_o = counter_overflow_flag && overflow_irq_enable;
  assign watchdog_function_o = watchdog_enable;

  // =====================================
  // read data; bit 4 has no storage behind it
  always @* begin
    sfr_rdata_o = 8'h00;
    if (addr_hit(sfr_addr_i, `CAM_MODE_ADDR))
      sfr_rdata_o = {idle_suspend, watchdog_enable, watchdog_lock, 1'b0,
                     timebase_select, overflow_irq_enable};
    else if (addr_hit(sfr_addr_i, `CAM_CTRL_ADDR))
      sfr_rdata_o = {counter_overflow_flag, counter_run, 6'h00};
  end
endmodule // cam_mode_ctrl

/* File: rtl/cam_sync.v */
`timescale 1ns/1ps
// =====================================
// two-stage synchroniser with falling-edge detect on the settled stage
module cam_sync (
  // clock and reset
  input  wire clk_sys_i,
  input  wire nrst_i,
  // async level in, sync level and fall pulse out
  input  wire async_i,
  output reg  level_o,
  output wire fall_o
);
  reg meta;
  reg prev;
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta    <= 1'b0;
      level_o <= 1'b0;
      prev    <= 1'b0;
    end else begin
      meta    <= async_i;
      level_o <= meta;
      prev    <= level_o;
    end
  end
  assign fall_o = prev & ~level_o;
endmodule // cam_sync

/* File: tb/cam_mode_chk.sv */
`timescale 1ns/1ps
// ========
// port checker for the mode control block
module cam_mode_chk (
  // clock and reset
  input wire        clk_sys_i,
  input wire        nrst_i,
  // register port
  input wire [7:0]  sfr_addr_i,
  input wire [7:0]  sfr_wdata_i,
  input wire        sfr_wr_i,
  input wire [7:0]  sfr_rdata_o,
  // sources and results
  input wire        cpu_idle_i,
  input wire        t0_ovf_i,
  input wire        ext_count_input_i,
  input wire        ext_clk_div8_i,
  input wire        rtc_clk_div8_i,
  input wire [15:0] counter_o,
  input wire        count_tick_o,
  input wire        watchdog_function_o,
  input wire        counter_array_irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  wire md = sfr_addr_i == 8'hD9;
  AST_TICK: assert property (count_tick_o |=> counter_o == $past(counter_o) + 16'h0001)
    else $error("counter step wrong");
  AST_WRAP: assert property (count_tick_o && counter_o == 16'hFFFF |=> counter_o == 16'h0000
    && (sfr_addr_i != 8'hD8 || sfr_rdata_o[7])) else $error("wrap wrong");
  AST_IRQ: assert property (md && !sfr_rdata_o[0] |-> !counter_array_irq_o)
    else $error("irq unmasked");
  AST_RSVD: assert property (md |-> !sfr_rdata_o[4])
    else $error("bit 4 set");
  AST_WDF: assert property (md |-> sfr_rdata_o[6] == watchdog_function_o)
    else $error("watchdog out wrong");
  AST_LOCK: assert property (md && sfr_rdata_o[6] && sfr_rdata_o[5] |=> watchdog_function_o)
    else $error("locked watchdog dropped");
  // both writes look at the fields other than enable and lock
  AST_FRZ: assert property (sfr_wr_i && md && sfr_rdata_o[6] ##1 md
    |-> (sfr_rdata_o & 8'h8F) == ($past(sfr_rdata_o) & 8'h8F)) else $error("frozen field moved");
  AST_WR: assert property (sfr_wr_i && md && !sfr_rdata_o[6] ##1 md
    |-> (sfr_rdata_o & 8'h8F) == ($past(sfr_wdata_i) & 8'h8F)) else $error("write lost");
endmodule // cam_mode_chk
bind cam_mode_ctrl cam_mode_chk chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sfr_addr_i(sfr_addr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rdata_o(sfr_rdata_o), .cpu_idle_i(cpu_idle_i),
  .t0_ovf_i(t0_ovf_i), .ext_count_input_i(ext_count_input_i), .ext_clk_div8_i(ext_clk_div8_i),
  .rtc_clk_div8_i(rtc_clk_div8_i), .counter_o(counter_o), .count_tick_o(count_tick_o),
  .watchdog_function_o(watchdog_function_o), .counter_array_irq_o(counter_array_irq_o));

/* File: tb/counter_array_mode_control_bench.sv */
`timescale 1ns/1ps
// ========
// random register traffic plus timebase corners
module counter_array_mode_control_bench;
  reg         clk_sys_i = 0, nrst_i = 0, sfr_wr_i = 0, cpu_idle_i = 0, t0_ovf_i = 0;
  reg         ext_count_input_i = 0, ext_clk_div8_i = 0, rtc_clk_div8_i = 0;
  reg  [7:0]  sfr_addr_i = 8'hD9, sfr_wdata_i = 8'h00, d;
  wire [7:0]  sfr_rdata_o;
  wire [15:0] counter_o;
  wire        count_tick_o, watchdog_function_o, counter_array_irq_o;
  integer     mismatches = 0, total_checks = 0, i, n, j;
  cam_mode_ctrl DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rdata_o(sfr_rdata_o), .cpu_idle_i(cpu_idle_i),
    .t0_ovf_i(t0_ovf_i), .ext_count_input_i(ext_count_input_i), .ext_clk_div8_i(ext_clk_div8_i),
    .rtc_clk_div8_i(rtc_clk_div8_i), .counter_o(counter_o), .count_tick_o(count_tick_o),
    .watchdog_function_o(watchdog_function_o), .counter_array_irq_o(counter_array_irq_o));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  // the overflow wait alone is just under 65536 cycles
  initial begin
    #800000 mismatches = mismatches + 1;
    test_done;
  end
  task chk(input string nm, input [15:0] s, input [15:0] e);
    begin
      total_checks = total_checks + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("mismatch %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk_sys_i) #1;
      sfr_addr_i = a;
      sfr_wdata_i = v;
      sfr_wr_i = 1;
      @(posedge clk_sys_i) #1;
      sfr_wr_i = 0;
      sfr_addr_i = 8'hD9;
    end
  endtask
  // the address changes only just after an edge; the read mux is looked at mid-cycle
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk_sys_i) #1;
      sfr_addr_i = a;
      #4 chk("register", sfr_rdata_o, e);
    end
  endtask
  // 48 cycles: t0 pulse every 3rd, five falls on the pins, sync latency fits
  function integer ticks(input [2:0] s);
    case (s)
      3'h0: ticks = 4;
      3'h1: ticks = 12;
      3'h2: ticks = 16;
      3'h4: ticks = 48;
      default: ticks = 5;
    endcase
  endfunction
  task run(input [7:0] m, input idle, input [15:0] e);
    begin
      wr(8'hD9, m);
      cpu_idle_i = idle;
      n = 0;
      for (i = 0; i < 48; i = i + 1) begin
        t0_ovf_i = i % 3 == 0;
        {ext_count_input_i, ext_clk_div8_i, rtc_clk_div8_i} = {3{i[2]}};
        #8 n = n + count_tick_o;
        @(posedge clk_sys_i) #1;
      end
      {cpu_idle_i, t0_ovf_i, ext_count_input_i, ext_clk_div8_i, rtc_clk_div8_i} = 5'h00;
      // the trailing pin fall must clear the synchroniser before the next selection counts
      repeat (3) @(posedge clk_sys_i);
      chk("ticks", n, e);
    end
  endtask
  task test_done;
    begin
      if (mismatches == 0 && total_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    n = $urandom(94);
    repeat (5) @(posedge clk_sys_i);
    #1 nrst_i = 1;
    rd(8'hD9, 8'h40);
    chk("watchdog", watchdog_function_o, 1);
    wr(8'hD9, 8'hCF);
    rd(8'hD9, 8'h40);
    wr(8'hD9, 8'h10);
    rd(8'hD9, 8'h00);
    chk("watchdog", watchdog_function_o, 0);
    repeat (6) begin
      d = $urandom & 8'h9F;
      wr(8'hD9, d);
      rd(8'hD9, d & 8'h8F);
      d = $urandom;
      rd({d[7:1], 1'b0}, 8'h00);
    end
    wr(8'hD8, 8'h40);
    for (j = 0; j < 7; j = j + 1)
      run({j[6:0], 1'b0}, 0, ticks(j[2:0]));
    run(8'h88, 1, 0);
    run(8'h08, 1, 48);
    wr(8'hD9, 8'h09);
    for (i = 0; counter_o !== 16'hFFFF && i < 70000; i = i + 1)
      @(posedge clk_sys_i) #1;
    chk("irq", counter_array_irq_o, 0);
    @(posedge clk_sys_i) #1;
    chk("counter", counter_o, 0);
    chk("irq", counter_array_irq_o, 1);
    rd(8'hD8, 8'hC0);
    wr(8'hD9, 8'h08);
    chk("irq", counter_array_irq_o, 0);
    wr(8'hD8, 8'h40);
    rd(8'hD8, 8'h40);
    wr(8'hD9, 8'h60);
    wr(8'hD9, 8'h00);
    rd(8'hD9, 8'h60);
    @(posedge clk_sys_i) #1;
    nrst_i = 0;
    repeat (2) @(posedge clk_sys_i);
    #1 nrst_i = 1;
    rd(8'hD9, 8'h40);
    wr(8'hD9, 8'h00);
    rd(8'hD9, 8'h00);
    test_done;
  end
endmodule // counter_array_mode_control_bench
